// ### rtl/pstp_patch_gather.sv
// Patch gatherer: collects a stream of patch-list vertices into one patch.
// Assumes the vertex count is stable while a patch is being gathered.
`timescale 1ns/1ps
module pstp_patch_gather
    import pstp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic [VCNT_W-1:0] vcount_i,
    input wire logic vtx_valid_i,
    input wire pstp_vertex_s vtx_i,
    output logic vtx_ready_o,
    output logic patch_valid_o,
    output pstp_patch_s patch_o,
    input wire logic patch_take_i
);

    logic [VCNT_W-1:0] seen_reg;
    logic full_reg;
    logic take_vtx;

    // Disabled stage swallows vertices so the stream never stalls
    assign vtx_ready_o = !full_reg || !enable_i;
    assign take_vtx = vtx_valid_i && vtx_ready_o && enable_i;
    assign patch_valid_o = full_reg;

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            seen_reg <= '0;
            full_reg <= 1'b0;
        end
        else if (patch_take_i)
        begin
            full_reg <= 1'b0;
        end
        else if (take_vtx)
        begin
            if (seen_reg + 1'b1 >= vcount_i)
            begin
                seen_reg <= '0;
                full_reg <= 1'b1;
            end
            else
            begin
                seen_reg <= seen_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            patch_o.prim_id <= '0;
            patch_o.record_handle <= '0;
        end
        else if (take_vtx && seen_reg == '0)
        begin
            patch_o.prim_id <= vtx_i.prim_id;
            patch_o.record_handle <= vtx_i.record_handle;
        end
    end

    // Only the first eight control points fit the single handle register
    for (genvar n = 0; n < ICP_SLOTS; n++)
    begin : g_slot
        always_ff @(posedge mclk_i)
        begin
            if (!resetn_i)
                patch_o.input_control_point[n] <= '0;
            else if (take_vtx && seen_reg == VCNT_W'(n))
                patch_o.input_control_point[n] <= vtx_i.input_control_point;
            else if (take_vtx && seen_reg == '0)
                patch_o.input_control_point[n] <= '0;
        end
    end

endmodule // pstp_patch_gather

// ### rtl/pstp_pkg.sv
// Package for the patch stage thread payload builder: register map, field
// layout, payload and stream structs, dispatch states.
// Assumes one 40 MHz clock and an AXI4-Lite master with 32-bit data.
// Overview of operation
// - Mask select 0 dispatch mask, 1 vector
// - Handle register sent only when handles included
// - Five-bit URB start register, ignored when disabled
// - Six-bit vertex read length, ignored when disabled
// - Six-bit vertex read offset, applied every vertex
// - Twelve-bit semaphore offset, region 32 dwords
// - Gather vertices into whole patches, then dispatch
// - Dword 6: dereference flag, 24-bit thread id
// - Dword 5 upper bits: scratch space pointer
// - Dword 5 low bits: thread tag 0-127
// - Dword 4: binding table pointer, 32-byte aligned
// - Dword 3: sampler state pointer, 32-byte granular
// - Dword 3 low nibble: scratch size, informational
// - Dword 2 top byte: semaphore dword index
// - Dword 2: instance number within patch
// - Dword 2: barrier index for gateway
// - Dword 2 low bits: semaphore handle
// - Dword 1: full primitive identifier
// - Dword 0: patch record handle, upper reserved
package pstp_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_SEMA = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SCRATCH = 8'h08;
    localparam logic [ADDR_W-1:0] REG_BIND = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_SAMPLER = 8'h10;
    localparam logic [ADDR_W-1:0] REG_TOPO = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h85f9_fbf0;
    localparam logic [31:0] SEMA_WMASK = 32'h0000_0fff;
    localparam logic [31:0] SCRATCH_WMASK = 32'hffff_fc0f;
    localparam logic [31:0] PTR_WMASK = 32'hffff_ffe0;
    localparam logic [31:0] TOPO_WMASK = 32'h0000_0f1f;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_EN_BIT = 31;
    localparam int CTRL_VECTOR_CHANNEL_MASK_BIT = 26;
    localparam int CTRL_INCL_BIT = 24;
    localparam int URB_START_LSB = 19;
    localparam int URB_START_W = 5;
    localparam int READ_LEN_LSB = 11;
    localparam int READ_OFF_LSB = 4;
    localparam int READ_W = 6;
    localparam int SEMA_W = 12;
    localparam int SCR_PTR_LSB = 10;
    localparam int SCR_SIZE_W = 4;
    localparam int TBL_PTR_LSB = 5;
    localparam int TOPO_VCNT_LSB = 0;
    localparam int TOPO_VCNT_W = 5;
    localparam int TOPO_INST_LSB = 8;
    localparam int TOPO_INST_W = 4;
    localparam int STAT_BUSY_BIT = 31;
    localparam int STAT_CNT_W = 16;

    // ----------------------------------------------------------------
    // Payload header layout
    // ----------------------------------------------------------------
    localparam int HDR_DWORDS = 8;
    localparam int ICP_SLOTS = 8;
    localparam int DW_RECORD = 0;
    localparam int DW_PRIM = 1;
    localparam int DW_SEMA = 2;
    localparam int DW_SAMPLER = 3;
    localparam int DW_BIND = 4;
    localparam int DW_SCRATCH = 5;
    localparam int DW_THREAD = 6;
    localparam int DEREF_BIT = 31;
    localparam int TID_W = 24;
    localparam int TAG_W = 7;
    localparam logic [TAG_W-1:0] TAG_MAX = 7'h7f;
    localparam int SEMA_IDX_LSB = 24;
    localparam int SEMA_IDX_W = 8;
    localparam int SEMA_REGION_DW_W = 5;
    localparam int INST_LSB = 16;
    localparam int INST_W = 7;
    localparam int BARRIER_LSB = 12;
    localparam int BARRIER_W = 4;
    localparam int VCNT_W = 6;
    localparam logic [15:0] DISPATCH_MASK_ALL = 16'hffff;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] handle_id;
        logic [15:0] handle;
    } pstp_icp_s;

    typedef struct packed {
        logic [31:0] prim_id;
        logic [15:0] record_handle;
        pstp_icp_s input_control_point;
    } pstp_vertex_s;

    typedef struct packed {
        logic [31:0] prim_id;
        logic [15:0] record_handle;
        pstp_icp_s [ICP_SLOTS-1:0] input_control_point;
    } pstp_patch_s;

    typedef struct packed {
        logic [HDR_DWORDS-1:0][31:0] header;
        pstp_icp_s [ICP_SLOTS-1:0] handles;
        logic handles_valid;
        logic [15:0] chan_mask;
        logic [URB_START_W-1:0] urb_start;
        logic [READ_W-1:0] read_len;
        logic [READ_W-1:0] read_off;
    } pstp_payload_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_DONE = 3'b100
    } pstp_state_e;

endpackage

// ### rtl/pstp_thread_payload.sv
// Top of the patch stage: AXI4-Lite state registers, patch gathering and
// per-instance thread payload dispatch.
// Assumes software idles the pipeline before it rewrites state.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pstp_thread_payload
    import pstp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic vtx_valid_i,
    input wire pstp_vertex_s vtx_i,
    output logic vtx_ready_o,
    input wire logic [15:0] vector_channel_mask_i,
    output logic thread_valid_o,
    input wire logic thread_ready_i,
    output pstp_payload_s thread_o
);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] sema_reg;
    logic [31:0] scratch_reg;
    logic [31:0] bind_reg;
    logic [31:0] sampler_reg;
    logic [31:0] topo_reg;
    logic [STAT_CNT_W-1:0] patch_cnt_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic [31:0] strb_mask;
    logic [31:0] rd_word;
    logic rd_hit;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    for (genvar b = 0; b < 4; b++)
    begin : g_strb
        assign strb_mask[b*8 +: 8] = {8{wstrb_reg[b]}};
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held_reg <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask);
        logic [31:0] m;
        m = strb_mask & wmask;
        return (old & ~m) | (wdata_reg & m);
    endfunction

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            ctrl_reg <= REG_RESET;
            sema_reg <= REG_RESET;
            scratch_reg <= REG_RESET;
            bind_reg <= REG_RESET;
            sampler_reg <= REG_RESET;
            topo_reg <= REG_RESET;
        end
        else if (do_write)
        begin
            case (awaddr_reg)
                REG_CTRL: ctrl_reg <= merge(ctrl_reg, CTRL_WMASK);
                REG_SEMA: sema_reg <= merge(sema_reg, SEMA_WMASK);
                REG_SCRATCH: scratch_reg <= merge(scratch_reg, SCRATCH_WMASK);
                REG_BIND: bind_reg <= merge(bind_reg, PTR_WMASK);
                REG_SAMPLER: sampler_reg <= merge(sampler_reg, PTR_WMASK);
                REG_TOPO: topo_reg <= merge(topo_reg, TOPO_WMASK);
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_reg == REG_CTRL || awaddr_reg == REG_SEMA ||
                            awaddr_reg == REG_SCRATCH || awaddr_reg == REG_BIND ||
                            awaddr_reg == REG_SAMPLER || awaddr_reg == REG_TOPO ||
                            awaddr_reg == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    pstp_state_e state_reg;

    always_comb
    begin
        rd_hit = 1'b1;
        rd_word = '0;
        case (s_axi_araddr)
            REG_CTRL: rd_word = ctrl_reg;
            REG_SEMA: rd_word = sema_reg;
            REG_SCRATCH: rd_word = scratch_reg;
            REG_BIND: rd_word = bind_reg;
            REG_SAMPLER: rd_word = sampler_reg;
            REG_TOPO: rd_word = topo_reg;
            REG_STATUS:
            begin
                rd_word[STAT_CNT_W-1:0] = patch_cnt_reg;
                rd_word[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Patch gathering
    // ----------------------------------------------------------------
    logic stage_en;
    logic patch_valid;
    logic patch_take;
    pstp_patch_s patch;
    logic [VCNT_W-1:0] vcount;
    logic [INST_W-1:0] inst_last;

    assign stage_en = ctrl_reg[CTRL_EN_BIT];
    assign vcount = VCNT_W'(topo_reg[TOPO_VCNT_LSB +: TOPO_VCNT_W]) + 1'b1;
    assign inst_last = INST_W'(topo_reg[TOPO_INST_LSB +: TOPO_INST_W]);
    assign patch_take = (state_reg == ST_DONE);

    pstp_patch_gather u_gather (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .enable_i(stage_en),
        .vcount_i(vcount),
        .vtx_valid_i(vtx_valid_i),
        .vtx_i(vtx_i),
        .vtx_ready_o(vtx_ready_o),
        .patch_valid_o(patch_valid),
        .patch_o(patch),
        .patch_take_i(patch_take)
    );

    // ----------------------------------------------------------------
    // Thread dispatch
    // ----------------------------------------------------------------
    logic [INST_W-1:0] inst_reg;
    logic [TID_W-1:0] tid_reg;
    logic [TAG_W-1:0] tag_reg;
    logic start;
    logic sent;
    logic build;
    logic [INST_W-1:0] build_inst;

    assign start = (state_reg == ST_IDLE) && patch_valid && stage_en;
    assign sent = (state_reg == ST_SEND) && thread_ready_i;
    assign build = start || (sent && inst_reg != inst_last);
    assign build_inst = start ? '0 : inst_reg + 1'b1;
    assign thread_valid_o = (state_reg == ST_SEND);

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            state_reg <= ST_IDLE;
        else
        begin
            unique case (state_reg)
                ST_IDLE: if (start) state_reg <= ST_SEND;
                ST_SEND: if (sent && inst_reg == inst_last) state_reg <= ST_DONE;
                ST_DONE: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            inst_reg <= '0;
        else if (build)
            inst_reg <= build_inst;
    end

    // Tags and ids advance per thread; a tag is reused after 128 threads
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            tid_reg <= '0;
            tag_reg <= '0;
        end
        else if (build)
        begin
            tid_reg <= tid_reg + 1'b1;
            tag_reg <= (tag_reg == TAG_MAX) ? '0 : tag_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            patch_cnt_reg <= '0;
        else if (patch_take)
            patch_cnt_reg <= patch_cnt_reg + 1'b1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            thread_o <= '0;
        else if (build)
        begin
            thread_o.header <= '0;
            thread_o.header[DW_RECORD][15:0] <= patch.record_handle;
            thread_o.header[DW_PRIM] <= patch.prim_id;
            thread_o.header[DW_SEMA][SEMA_IDX_LSB +: SEMA_IDX_W] <=
                SEMA_IDX_W'(patch_cnt_reg[SEMA_REGION_DW_W-1:0]);
            thread_o.header[DW_SEMA][INST_LSB +: INST_W] <= build_inst;
            thread_o.header[DW_SEMA][BARRIER_LSB +: BARRIER_W] <=
                patch_cnt_reg[BARRIER_W-1:0];
            thread_o.header[DW_SEMA][SEMA_W-1:0] <= sema_reg[SEMA_W-1:0];
            thread_o.header[DW_SAMPLER][31:TBL_PTR_LSB] <=
                sampler_reg[31:TBL_PTR_LSB];
            thread_o.header[DW_SAMPLER][SCR_SIZE_W-1:0] <=
                scratch_reg[SCR_SIZE_W-1:0];
            thread_o.header[DW_BIND][31:TBL_PTR_LSB] <= bind_reg[31:TBL_PTR_LSB];
            thread_o.header[DW_SCRATCH][31:SCR_PTR_LSB] <=
                scratch_reg[31:SCR_PTR_LSB];
            thread_o.header[DW_SCRATCH][TAG_W-1:0] <= tag_reg;
            thread_o.header[DW_THREAD][DEREF_BIT] <= ctrl_reg[CTRL_INCL_BIT];
            thread_o.header[DW_THREAD][TID_W-1:0] <= tid_reg;
            thread_o.handles_valid <= ctrl_reg[CTRL_INCL_BIT];
            thread_o.handles <= ctrl_reg[CTRL_INCL_BIT] ? patch.input_control_point : '0;
            // Vector mask for SIMD-style kernels, full dispatch mask otherwise
            thread_o.chan_mask <= ctrl_reg[CTRL_VECTOR_CHANNEL_MASK_BIT] ?
                vector_channel_mask_i : DISPATCH_MASK_ALL;
            thread_o.urb_start <= ctrl_reg[URB_START_LSB +: URB_START_W];
            thread_o.read_len <= ctrl_reg[READ_LEN_LSB +: READ_W];
            thread_o.read_off <= ctrl_reg[READ_OFF_LSB +: READ_W];
        end
    end

endmodule // pstp_thread_payload

// ### tb/pstp_chk.sv
// Checker for the patch stage top: payload header and handshake properties.
// Assumes it is bound to pstp_thread_payload and sees only its ports.
`timescale 1ns/1ps
module pstp_chk
    import pstp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic thread_valid_o,
    input wire logic thread_ready_i,
    input wire pstp_payload_s thread_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    logic [6:0] inst;
    logic [23:0] tid;
    logic take;
    assign inst = thread_o.header[DW_SEMA][22:16];
    assign tid = thread_o.header[DW_THREAD][23:0];
    assign take = thread_valid_o && thread_ready_i;

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_payload_hold: assert property (thread_valid_o && !thread_ready_i
        |=> thread_valid_o && $stable(thread_o)) else $error("payload moved");
    a_handles_off: assert property (thread_valid_o && !thread_o.handles_valid
        |-> thread_o.handles == '0) else $error("handles without include");
    a_deref_flag: assert property (thread_valid_o
        |-> thread_o.header[DW_THREAD][DEREF_BIT] == thread_o.handles_valid)
        else $error("dereference flag wrong");
    a_record_upper: assert property (thread_valid_o
        |-> thread_o.header[DW_RECORD][31:16] == 16'h0) else $error("record upper");
    a_tag_range: assert property (thread_valid_o
        |-> thread_o.header[DW_SCRATCH][9:7] == 3'h0) else $error("thread tag range");
    a_table_align: assert property (thread_valid_o
        |-> thread_o.header[DW_BIND][4:0] == 5'h0 && !thread_o.header[DW_SAMPLER][4])
        else $error("table pointer alignment");
    a_inst_step: assert property (take ##1 thread_valid_o
        |-> inst == $past(inst) + 7'h1) else $error("instance step");
    a_tid_step: assert property (take ##1 thread_valid_o
        |-> tid == $past(tid) + 24'h1) else $error("thread id step");
    c_take_handles: cover property (take && thread_o.handles_valid);
    c_back_to_back: cover property (take ##1 take);
    c_write_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule // pstp_chk

bind pstp_thread_payload pstp_chk u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .thread_valid_o(thread_valid_o), .thread_ready_i(thread_ready_i), .thread_o(thread_o));

// ### tb/pstp_shader_model.sv
// Shader side model: takes dispatched payloads, promptly or every other cycle.
// Assumes the bench reads the collected payloads from rx_q.
`timescale 1ns/1ps
module pstp_shader_model
    import pstp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic slow_i,
    input wire logic thread_valid_i,
    input wire pstp_payload_s payload_i,
    output logic thread_ready_o
);
    pstp_payload_s rx_q[$];
    // Slow mode toggles ready so that payloads must wait while valid
    always @(posedge mclk_i)
    begin
        if (!resetn_i)
            thread_ready_o <= 1'b0;
        else
        begin
            thread_ready_o <= slow_i ? ~thread_ready_o : 1'b1;
            if (thread_valid_i && thread_ready_o)
                rx_q.push_back(payload_i);
        end
    end
endmodule // pstp_shader_model

// ### tb/pstp_thread_payload_tb_top.sv
// Testbench top: state registers over AXI4-Lite, vertex stream, payload checks.
// Assumes the checker is bound and the shader model collects payloads.
`timescale 1ns/1ps
module pstp_thread_payload_tb_top
    import pstp_pkg::*;
();
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, vtx_valid = 1'b0, slow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, vtx_ready, thr_valid, thr_ready;
    logic [1:0] bresp, rresp;
    pstp_vertex_s vtx = '0;
    pstp_vertex_s v[8];
    pstp_payload_s thr;
    int fails = 0;
    int n_compared = 0;
    localparam logic [7:0] TA[6] = '{REG_CTRL, REG_SEMA, REG_SCRATCH, REG_BIND,
        REG_SAMPLER, REG_TOPO};
    localparam logic [31:0] TW[6] = '{32'hffff_ffff, 32'hffff_ffff, 32'habcd_e40b,
        32'hffff_ffff, 32'h1234_567f, 32'h0000_0102};
    localparam logic [31:0] TR[6] = '{CTRL_WMASK, 32'h0000_0fff, 32'habcd_e40b,
        32'hffff_ffe0, 32'h1234_5660, 32'h0000_0102};
    always #12.5 mclk_i = ~mclk_i;

    pstp_thread_payload dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .vtx_valid_i(vtx_valid), .vtx_i(vtx), .vtx_ready_o(vtx_ready),
        .vector_channel_mask_i(16'ha5c3), .thread_valid_o(thr_valid),
        .thread_ready_i(thr_ready), .thread_o(thr));
    pstp_shader_model model (.mclk_i(mclk_i), .resetn_i(resetn_i), .slow_i(slow),
        .thread_valid_i(thr_valid), .payload_i(thr), .thread_ready_o(thr_ready));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // A wait that ran out ends the run at once
    task automatic bail(input logic ok);
        if (!ok)
        begin
            fails++;
            final_report();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, done;
        logic [1:0] rs;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(negedge mclk_i);
            ta = awready;
            tw = wready;
            done = bvalid;
            rs = bresp;
            @(posedge mclk_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bail(done);
        check({30'h0, rs}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, done;
        logic [1:0] rs;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(negedge mclk_i);
            ta = arready;
            done = rvalid;
            rs = rresp;
            rd = rdata;
            @(posedge mclk_i);
            if (ta) arvalid <= 1'b0;
        end
        bail(done);
        check(rd, ed);
        check({30'h0, rs}, {30'h0, er});
    endtask

    // Valid stays up between vertices of one patch
    task automatic send_patch(input int cnt, input logic [15:0] base);
        logic ta;
        int k;
        k = 0;
        for (int j = 0; j < 8; j++)
            v[j] = '{{base, 16'(j)}, base + 16'(j), '{16'h5000 + 16'(j), base ^ 16'(j)}};
        vtx <= v[0];
        vtx_valid <= 1'b1;
        for (int n = 0; n < 200 && k < cnt; n++)
        begin
            @(negedge mclk_i);
            ta = vtx_ready;
            @(posedge mclk_i);
            if (ta) k++;
            if (ta) vtx <= v[k % 8];
        end
        vtx_valid <= 1'b0;
        bail(k == cnt);
    endtask

    task automatic wait_rx(input int k);
        for (int n = 0; n < 300 && model.rx_q.size() < k; n++) @(posedge mclk_i);
        bail(model.rx_q.size() >= k);
    endtask

    task automatic check_pay(input pstp_payload_s p, input logic [6:0] inst, input logic incl,
        input logic [15:0] m, input logic [16:0] ulo, input int cnt, input logic [3:0] pn);
        check(p.header[DW_RECORD], {16'h0, v[0].record_handle});
        check(p.header[DW_PRIM], v[0].prim_id);
        check({25'h0, p.header[DW_SEMA][22:16]}, {25'h0, inst});
        check({24'h0, p.header[DW_SEMA][31:24]}, {28'h0, pn});
        check({16'h0, p.header[DW_SEMA][15:0]}, {16'h0, pn, 12'hfff});
        check(p.header[DW_SAMPLER], 32'h1234_566b);
        check(p.header[DW_BIND], 32'hffff_ffe0);
        check({p.header[DW_SCRATCH][31:10], 10'h0}, 32'habcd_e400);
        check({31'h0, p.header[DW_THREAD][DEREF_BIT]}, {31'h0, incl});
        check({31'h0, p.handles_valid}, {31'h0, incl});
        check({16'h0, p.chan_mask}, {16'h0, m});
        check({15'h0, p.urb_start, p.read_len, p.read_off}, {15'h0, ulo});
        for (int j = 0; j < cnt; j++)
            check(p.handles[j], incl ? v[j].input_control_point : 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 7; i++) axi_rd(8'(4 * i), REG_RESET, RESP_OKAY);
        for (int i = 0; i < 6; i++) axi_wr(TA[i], TW[i], RESP_OKAY);
        for (int i = 0; i < 6; i++) axi_rd(TA[i], TR[i], RESP_OKAY);
        axi_wr(8'h1c, 32'h0000_00ff, RESP_SLVERR);
        axi_rd(8'h1c, 32'h0, RESP_SLVERR);
        $display("test registers done");
        slow <= 1'b1;
        send_patch(3, 16'h7100);
        wait_rx(2);
        check_pay(model.rx_q[0], 7'h0, 1'b1, 16'ha5c3, {5'h1f, 6'h3f, 6'h3f}, 3, 4'h0);
        check_pay(model.rx_q[1], 7'h1, 1'b1, 16'ha5c3, {5'h1f, 6'h3f, 6'h3f}, 3, 4'h0);
        $display("test two instances done");
        slow <= 1'b0;
        axi_wr(REG_CTRL, 32'h8028_1010, RESP_OKAY);
        axi_wr(REG_TOPO, 32'h0000_0007, RESP_OKAY);
        send_patch(8, 16'h7200);
        wait_rx(3);
        check_pay(model.rx_q[2], 7'h0, 1'b0, 16'hffff, {5'h05, 6'h02, 6'h01}, 8, 4'h1);
        $display("test eight vertices done");
        axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
        send_patch(8, 16'h7300);
        repeat (30) @(posedge mclk_i);
        check(32'(model.rx_q.size()), 32'h3);
        axi_wr(REG_STATUS, 32'hffff_ffff, RESP_OKAY);
        axi_rd(REG_STATUS, 32'h0000_0002, RESP_OKAY);
        $display("test disabled stage done");
        final_report();
    end
endmodule // pstp_thread_payload_tb_top
